// [src/srcp_defines.svh]
`ifndef SRCP_DEFINES_SVH
`define SRCP_DEFINES_SVH

// System clock rate in kHz
`define SRCP_SYS_CLK_KHZ      50000
// Least watchdog reset pulse, in ms
`define SRCP_WDOG_PULSE_MS    200
// Cycles for the least pulse, exact product of ms and kHz
`define SRCP_WDOG_PULSE_CYC   ((`SRCP_WDOG_PULSE_MS * `SRCP_SYS_CLK_KHZ))
// Least hold of the chip reset input, in system clock cycles
`define SRCP_RESET_MIN_CYC    256
// Synchroniser length
`define SRCP_SYNC_STAGES      2
// Divide ratio for the PHY reference: 50 MHz / 2 = 25 MHz
`define SRCP_PHY_DIV_HALF     1

`endif

// [src/srcp_pkg.sv]
package srcp_pkg;

  typedef enum logic [1:0] {
    SRCP_IN_RESET,
    SRCP_RUN
  } srcp_mode_t;

  typedef struct packed {
    logic ddr_true;
    logic ddr_comp;
    logic cke;
  } srcp_ddr_pin_t;

  typedef struct packed {
    logic [1:0]    rst_sync;
    srcp_mode_t    mode;
    logic [31:0]   wd_count;
    logic          wd_active;
    logic          phy_clk;
    logic          ddr_phase;
    logic          blocks_rst_n;
    logic          out_en;
    logic [1:0]    ddr_true;
    logic [1:0]    ddr_comp;
    logic          cke;
  } srcp_state_t;

endpackage

// [src/srcp_top.sv]
`include "srcp_defines.svh"
// Overview of operation
// - Hold processor core and every functional block in reset while chip reset low.
// - In reset pins_out_en drops and open-drain signals are released; PHY and DDR clocks keep running.
// - Watchdog expiry while running drives watchdog reset output for at least 200 ms, unless chip reset entry cuts it short.
// - Drive a continuous 25 MHz reference clock for the external PHY.
// - Drive two differential DDR clock pairs derived from the system clock.
// - Drive a DDR clock enable used to enter memory power-down.
module srcp_top #(
  parameter int unsigned WDOG_PULSE_CYC = `SRCP_WDOG_PULSE_CYC,
  parameter int unsigned DDR_PAIRS      = 2
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  chip_reset_in_low,
  input  wire logic                  wdog_expire,
  input  wire logic                  ddr_power_down_req,
  output logic                       core_reset_low,
  output logic                       pins_out_en,
  output logic                       watchdog_reset_out,
  output logic                       watchdog_reset_out_en,
  output logic                       phy_ref_clock_out,
  output logic [DDR_PAIRS-1:0]       ddr_clock_out_true,
  output logic [DDR_PAIRS-1:0]       ddr_clock_out_comp,
  output logic                       sdram_clk_enable_out
);

  // Registered state of the whole block
  srcp_pkg::srcp_state_t s_q;
  srcp_pkg::srcp_state_t s_d;

  // Reset pin after synchronisation
  logic                  sync_first;
  logic                  rel;

  // Mode decode and mode changes
  logic                  in_reset;
  logic                  in_run;
  logic                  enter_reset;
  logic                  leave_reset;

  // Watchdog pulse helpers
  logic                  wd_load;
  logic                  wd_busy;
  logic                  wd_last;
  logic [31:0]           wd_reload;
  logic [31:0]           wd_less;

  // Memory clock enable while running
  logic                  cke_run;

  // Clock phases for the next edge
  logic                  phy_next;
  logic                  phase_next;
  logic [1:0]            pair_true;
  logic [1:0]            pair_comp;

  // The first stage may be metastable: only the second stage feeds
  // anything, so the release is seen two edges after the pin
  assign sync_first = s_q.rst_sync[0];
  assign rel        = s_q.rst_sync[1];

  // Decoded mode
  assign in_reset = (s_q.mode == srcp_pkg::SRCP_IN_RESET);
  assign in_run   = (s_q.mode == srcp_pkg::SRCP_RUN);

  // Entry is immediate, no filtering beyond the synchroniser
  assign enter_reset = in_run && !rel;

  // One release edge for every block
  assign leave_reset = in_reset && rel;

  // Expiry counts only while running; in reset it is ignored
  assign wd_load = in_run && wdog_expire;
  assign wd_busy = s_q.wd_active;
  assign wd_last = (s_q.wd_count == 32'h0000_0000);

  // Load value gives a pulse of WDOG_PULSE_CYC cycles
  assign wd_reload = WDOG_PULSE_CYC - 32'h0000_0001;
  assign wd_less   = s_q.wd_count - 32'h0000_0001;

  // Clock enable low asks the memory to enter power-down
  assign cke_run = ~ddr_power_down_req;

  // PHY reference toggles every cycle: 50 MHz / 2
  assign phy_next = ~s_q.phy_clk;

  // One shared phase for every DDR pair
  assign phase_next = ~s_q.ddr_phase;

  // Each pair has a true leg and its inverse
  for (genvar p = 0; p < DDR_PAIRS; p++) begin : g_pair
    assign pair_true[p] = phase_next;
    assign pair_comp[p] = ~phase_next;
  end

  always_comb begin
    s_d = s_q;

    // Two-flop synchroniser for the board reset pin
    s_d.rst_sync[0] = chip_reset_in_low;
    s_d.rst_sync[1] = sync_first;

    // Reference clock runs even in reset, so the PHY never stalls
    s_d.phy_clk = phy_next;

    // DDR clocks run in reset too; the memory keeps a steady clock
    s_d.ddr_phase = phase_next;
    s_d.ddr_true  = pair_true;
    s_d.ddr_comp  = pair_comp;

    unique case (s_q.mode)
      srcp_pkg::SRCP_IN_RESET: begin
        if (leave_reset) begin
          s_d.mode = srcp_pkg::SRCP_RUN;
        end else begin
          s_d.mode = srcp_pkg::SRCP_IN_RESET;
        end
      end
      srcp_pkg::SRCP_RUN: begin
        if (enter_reset) begin
          s_d.mode = srcp_pkg::SRCP_IN_RESET;
        end else begin
          s_d.mode = srcp_pkg::SRCP_RUN;
        end
      end
    endcase

    // Core and block reset follow the next mode on the same edge
    if (s_d.mode == srcp_pkg::SRCP_RUN) begin
      s_d.blocks_rst_n = 1'b1;
    end else begin
      s_d.blocks_rst_n = 1'b0;
    end

    // Pins float for as long as the blocks are held
    if (s_d.mode == srcp_pkg::SRCP_RUN) begin
      s_d.out_en = 1'b1;
    end else begin
      s_d.out_en = 1'b0;
    end

    // Clock enable is forced low in reset and on the release edge,
    // then tracks the power-down request one edge behind
    if (in_run && !enter_reset) begin
      s_d.cke = cke_run;
    end else begin
      s_d.cke = 1'b0;
    end

    // Watchdog pulse: a fresh expiry restarts the full length
    if (!in_run) begin
      s_d.wd_active = 1'b0;
      s_d.wd_count  = 32'h0000_0000;
    end else if (wd_load) begin
      s_d.wd_active = 1'b1;
      s_d.wd_count  = wd_reload;
    end else if (wd_busy && wd_last) begin
      s_d.wd_active = 1'b0;
    end else if (wd_busy) begin
      s_d.wd_count  = wd_less;
    end

    // Reset entry drops the pulse at once; its pin floats anyway
    if (enter_reset) begin
      s_d.wd_active = 1'b0;
    end
  end

  // Synchronous reset: the complement legs start high so that each
  // pair is already differential on the first edge after reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q          <= '0;
      s_q.mode     <= srcp_pkg::SRCP_IN_RESET;
      s_q.ddr_comp <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a bare register bit, no logic after the flop
  assign core_reset_low        = s_q.blocks_rst_n;
  assign pins_out_en           = s_q.out_en;
  assign watchdog_reset_out    = s_q.wd_active;
  assign watchdog_reset_out_en = s_q.out_en;
  assign phy_ref_clock_out     = s_q.phy_clk;
  assign ddr_clock_out_true    = s_q.ddr_true;
  assign ddr_clock_out_comp    = s_q.ddr_comp;
  assign sdram_clk_enable_out  = s_q.cke;

endmodule

// [verif/srcp_top_chk_sva.sv]
module srcp_top_chk #(
  parameter int unsigned WDOG_PULSE_CYC = 20,
  parameter int unsigned DDR_PAIRS      = 2
) (
  input wire logic                 sys_clk,
  input wire logic                 nrst,
  input wire logic                 chip_reset_in_low,
  input wire logic                 wdog_expire,
  input wire logic                 ddr_power_down_req,
  input wire logic                 core_reset_low,
  input wire logic                 pins_out_en,
  input wire logic                 watchdog_reset_out,
  input wire logic                 watchdog_reset_out_en,
  input wire logic                 phy_ref_clock_out,
  input wire logic [DDR_PAIRS-1:0] ddr_clock_out_true,
  input wire logic [DDR_PAIRS-1:0] ddr_clock_out_comp,
  input wire logic                 sdram_clk_enable_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  hold_core_a: assert property (
    !chip_reset_in_low [*4] |-> !core_reset_low) else $error("core not held");
  pins_quiet_a: assert property (
    !core_reset_low |-> !pins_out_en && !watchdog_reset_out_en)
    else $error("pins driven in reset");
  wdog_start_a: assert property (
    wdog_expire && core_reset_low && $past(chip_reset_in_low, 2)
      |=> watchdog_reset_out) else $error("no wdog");
  wdog_len_a: assert property (
    $rose(watchdog_reset_out) |-> ##19 watchdog_reset_out)
    else $error("wdog pulse short");
  phy_toggle_a: assert property (
    core_reset_low |-> $changed(phy_ref_clock_out)) else $error("phy clock");
  ddr_pair_a: assert property (
    core_reset_low |-> $changed(ddr_clock_out_true)
      && ddr_clock_out_comp == ~ddr_clock_out_true) else $error("ddr pair");
  cke_track_a: assert property (
    core_reset_low && $past(chip_reset_in_low, 2)
      |=> sdram_clk_enable_out == !$past(ddr_power_down_req))
    else $error("cke");
  sync_release_a: assert property (
    $rose(chip_reset_in_low) ##1 chip_reset_in_low [*2] |=> core_reset_low)
    else $error("late release");
endmodule

// [verif/srcp_board_model.sv]
module srcp_board_model (
  input wire logic sys_clk,
  input wire logic pulse,
  output logic     chip_reset_in_low
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned left = 0;
  initial chip_reset_in_low = 1'b1;
  // Supervisor keeps the pin low for the full minimum once it starts
  always @(posedge sys_clk) begin
    left <= pulse ? 256 : (left > 0 ? left - 1 : 0);
    chip_reset_in_low <= !(pulse || left > 1);
  end
endmodule

// [verif/srcp_tb_top.sv]
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module srcp_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, nrst = 0, wdog_expire = 0, ddr_power_down_req = 0;
  logic pulse = 0, chip_reset_in_low, core_reset_low, pins_out_en, k1;
  logic watchdog_reset_out, watchdog_reset_out_en, phy_ref_clock_out;
  logic sdram_clk_enable_out;
  logic [1:0] ddr_clock_out_true, ddr_clock_out_comp;
  int err_total = 0, n_compared = 0, k;
  initial forever #10 sys_clk = ~sys_clk;
  srcp_board_model u_srcp_board_model(.sys_clk, .pulse, .chip_reset_in_low);
  srcp_top #(.WDOG_PULSE_CYC(20)) u_srcp_top(.sys_clk, .nrst,
    .chip_reset_in_low, .wdog_expire, .ddr_power_down_req, .core_reset_low,
    .pins_out_en, .watchdog_reset_out, .watchdog_reset_out_en,
    .phy_ref_clock_out, .ddr_clock_out_true, .ddr_clock_out_comp,
    .sdram_clk_enable_out);
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run;
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #1ms;
    err_total++;
    complete_run;
  end
  initial begin
    void'($urandom(32'hFBC31858));
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    step(5);
    `CHK("core_reset_low", 1'b1, core_reset_low)
    `CHK("pins_out_en", 1'b1, pins_out_en)
    `CHK("wdog_out_en", 1'b1, watchdog_reset_out_en)
    k1 = phy_ref_clock_out;
    step(1);
    `CHK("phy_ref_clock_out", !k1, phy_ref_clock_out)
    `CHK("ddr_clock_out_comp", ~ddr_clock_out_true, ddr_clock_out_comp)
    repeat (16) begin
      @(posedge sys_clk) ddr_power_down_req <= 1'($urandom);
      step(1);
      `CHK("cke", !ddr_power_down_req, sdram_clk_enable_out)
    end
    @(posedge sys_clk) wdog_expire <= 1'b1;
    @(posedge sys_clk) wdog_expire <= 1'b0;
    k = 0;
    #1;
    repeat (24) begin
      k += int'(watchdog_reset_out);
      step(1);
    end
    `CHK("wdog pulse cycles", 20, k)
    @(posedge sys_clk) pulse <= 1'b1;
    @(posedge sys_clk) pulse <= 1'b0;
    step(250);
    `CHK("core_reset_low", 1'b0, core_reset_low)
    `CHK("pins_out_en", 1'b0, pins_out_en)
    `CHK("wdog_out_en", 1'b0, watchdog_reset_out_en)
    `CHK("cke", 1'b0, sdram_clk_enable_out)
    step(20);
    `CHK("core_reset_low", 1'b1, core_reset_low)
    complete_run;
  end
endmodule
bind srcp_top srcp_top_chk #(.WDOG_PULSE_CYC(WDOG_PULSE_CYC),
  .DDR_PAIRS(DDR_PAIRS)) u_srcp_top_chk(.sys_clk, .nrst, .chip_reset_in_low,
  .wdog_expire, .ddr_power_down_req, .core_reset_low, .pins_out_en,
  .watchdog_reset_out, .watchdog_reset_out_en, .phy_ref_clock_out,
  .ddr_clock_out_true, .ddr_clock_out_comp, .sdram_clk_enable_out);
